// ===== core/tpw_channel.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] Edge PWM, clock on: compare loads at count step top-1 to top.
// [RULE_02] Center PWM, clock on: compare loads at count step top-1 to top.
// [RULE_03] Free-running counter: compare loads on step FFFE to FFFF.
// [RULE_04] Center PWM, compare equal to modulo: output active all period.
// [RULE_05] Center PWM, compare equal modulo minus one: nearly full duty.
// [RULE_06] Compare zero to nonzero: old output kept until new period.
// [RULE_07] Compare nonzero to zero: current period ends with old duty.
// [RULE_08] Status write in halt debug drops half-written modulo value.
// [RULE_09] Any write to count bytes clears counter and prescaler.
// [RULE_10] Center PWM counts up to modulo, down to zero, repeats.
// [RULE_11] Center PWM: active on down-count match, inactive on up match. Code stays inactive at the down match and goes active one count later.
// [RULE_12] Pending flag set when both bytes written, cleared on transfer.
module tpw_channel (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire tpw_pkg::tpw_bus_t bus_req,
  input  wire logic              halt_debug_mode,
  output logic            [7:0]  rdata,
  output logic                   chan_pin,
  output logic                   chan_pin_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tpw_pkg::tpw_sc_t   sc;
  tpw_pkg::tpw_sc_t   next_sc;
  tpw_pkg::tpw_chsc_t chsc;
  tpw_pkg::tpw_chsc_t next_chsc;
  tpw_pkg::tpw_dir_t  dir;
  tpw_pkg::tpw_dir_t  next_dir;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [7:0]  presc;
  logic [7:0]  next_presc;
  logic [7:0]  presc_limit;
  logic [15:0] counter_modulo;
  logic [15:0] val_buf;
  logic [15:0] channel_compare_value;
  logic [15:0] next_ccv;
  logic        val_pending;
  logic        next_pending;
  logic        val_done;
  logic        mod_half;
  logic        chan_pin_next;
  logic [7:0]  next_rdata;
  logic [15:0] top;
  logic [15:0] top_less;
  logic        free_run;
  logic        run;
  logic        tick;
  logic        cnt_wr;
  logic        sc_wr;
  logic        xfer;
  logic        active;

  // ----------------------------------------------------------------
  // Bus decode and buffered registers
  // ----------------------------------------------------------------
  // Write strobes per address
  assign sc_wr  = bus_req.wr && bus_req.addr == tpw_pkg::OFS_SC;
  assign cnt_wr = bus_req.wr && (bus_req.addr == tpw_pkg::OFS_CNTH ||
                                 bus_req.addr == tpw_pkg::OFS_CNTL);

  // [RULE_08] coherency clear in debug
  tpw_pair_buf u_mod_buf (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr_hi   (bus_req.wr && bus_req.addr == tpw_pkg::OFS_MODH),
    .wr_lo   (bus_req.wr && bus_req.addr == tpw_pkg::OFS_MODL),
    .wdata   (bus_req.wdata),
    .clear   (sc_wr && halt_debug_mode),
    .value   (counter_modulo),
    .done    (),
    .half    (mod_half)
  );

  // Status write also restarts the compare pair, so setup order is SC first
  tpw_pair_buf u_val_buf (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr_hi   (bus_req.wr && bus_req.addr == tpw_pkg::OFS_CHVH),
    .wr_lo   (bus_req.wr && bus_req.addr == tpw_pkg::OFS_CHVL),
    .wdata   (bus_req.wdata),
    .clear   (sc_wr),
    .value   (val_buf),
    .done    (val_done),
    .half    ()
  );

  // ----------------------------------------------------------------
  // Counter timing terms
  // ----------------------------------------------------------------
  // Modulo of zero or all ones means no limit
  assign free_run    = counter_modulo == tpw_pkg::COUNT_ZERO ||
                       counter_modulo == tpw_pkg::COUNT_MAX;
  assign top         = free_run ? tpw_pkg::COUNT_MAX : counter_modulo;
  assign top_less    = top - tpw_pkg::COUNT_ONE;
  assign presc_limit = (tpw_pkg::PS_ONE << sc.ps) - tpw_pkg::PS_ONE;
  // Counting freezes while halted in debug
  assign run  = sc.clock_source_select != tpw_pkg::CLKS_OFF &&
                !halt_debug_mode;
  assign tick = run && presc == presc_limit;

  // [RULE_01] [RULE_02] [RULE_03] transfer point
  // The step into top is always an up step, in either alignment
  assign xfer = val_pending &&
                (sc.clock_source_select == tpw_pkg::CLKS_OFF ||
                 (tick && !cnt_wr && dir == tpw_pkg::DIR_UP &&
                  cnt == top_less));

  // ----------------------------------------------------------------
  // Control registers and counter
  // ----------------------------------------------------------------
  // Next control state and count
  always_comb begin
    next_sc    = sc;
    next_chsc  = chsc;
    next_cnt   = cnt;
    next_presc = presc;
    next_dir   = dir;
    if (sc_wr) begin
      next_sc      = bus_req.wdata;
      next_sc.rsvd = 2'b00;
    end
    if (bus_req.wr && bus_req.addr == tpw_pkg::OFS_CHSC) begin
      next_chsc.pwm_en   = bus_req.wdata[1];
      next_chsc.low_true = bus_req.wdata[0];
    end
    // [RULE_09] count write clears all
    if (cnt_wr) begin
      next_cnt   = tpw_pkg::COUNT_ZERO;
      next_presc = tpw_pkg::BYTE_ZERO;
      next_dir   = tpw_pkg::DIR_UP;
    end else if (run) begin
      next_presc = tick ? tpw_pkg::BYTE_ZERO : presc + tpw_pkg::PS_ONE;
      if (tick) begin
        if (!sc.cpwm) begin
          next_dir = tpw_pkg::DIR_UP;
          next_cnt = (cnt >= top) ? tpw_pkg::COUNT_ZERO
                                  : cnt + tpw_pkg::COUNT_ONE;
        end else begin
          // [RULE_10] up to top, down to zero
          unique case (dir)
            tpw_pkg::DIR_UP: begin
              if (cnt >= top) begin
                next_dir = tpw_pkg::DIR_DOWN;
                next_cnt = cnt - tpw_pkg::COUNT_ONE;
              end else begin
                next_cnt = cnt + tpw_pkg::COUNT_ONE;
              end
            end
            tpw_pkg::DIR_DOWN: begin
              if (cnt == tpw_pkg::COUNT_ZERO) begin
                next_dir = tpw_pkg::DIR_UP;
                next_cnt = tpw_pkg::COUNT_ONE;
              end else begin
                next_cnt = cnt - tpw_pkg::COUNT_ONE;
              end
            end
            default: begin
              next_dir = tpw_pkg::DIR_UP;
            end
          endcase
        end
      end
    end
  end

  // Control state registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sc    <= tpw_pkg::SC_RST;
      chsc  <= tpw_pkg::CHSC_RST;
      cnt   <= tpw_pkg::COUNT_ZERO;
      presc <= tpw_pkg::BYTE_ZERO;
      dir   <= tpw_pkg::DIR_UP;
    end else begin
      sc    <= next_sc;
      chsc  <= next_chsc;
      cnt   <= next_cnt;
      presc <= next_presc;
      dir   <= next_dir;
    end
  end

  // ----------------------------------------------------------------
  // Compare value, output and read data
  // ----------------------------------------------------------------
  // [RULE_04] [RULE_05] [RULE_11] center compare
  // Compare at top forces full duty; plain match gives symmetric pulse
  always_comb begin
    if (sc.cpwm) begin
      active = channel_compare_value == top || cnt < channel_compare_value;
    end else begin
      active = cnt < channel_compare_value;
    end
    chan_pin_next = (sc.cpwm || chsc.pwm_en) ? (active ^ chsc.low_true)
                                             : 1'b0;
  end

  // [RULE_12] pending, set beats clear
  // [RULE_06] [RULE_07] loads at period edge, or at once with clock off
  always_comb begin
    next_pending = val_done | (val_pending & ~xfer);
    next_ccv     = xfer ? val_buf : channel_compare_value;
    next_rdata   = tpw_pkg::BYTE_ZERO;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        tpw_pkg::OFS_SC:   next_rdata = sc;
        tpw_pkg::OFS_CNTH: next_rdata = cnt[15:8];
        tpw_pkg::OFS_CNTL: next_rdata = cnt[7:0];
        tpw_pkg::OFS_MODH: next_rdata = counter_modulo[15:8];
        tpw_pkg::OFS_MODL: next_rdata = counter_modulo[7:0];
        tpw_pkg::OFS_CHSC: next_rdata = {val_pending, chsc[6:0]};
        tpw_pkg::OFS_CHVH: next_rdata = channel_compare_value[15:8];
        tpw_pkg::OFS_CHVL: next_rdata = channel_compare_value[7:0];
      endcase
    end
  end

  // Output and value registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      val_pending           <= 1'b0;
      channel_compare_value <= tpw_pkg::COUNT_ZERO;
      rdata                 <= tpw_pkg::BYTE_ZERO;
      chan_pin              <= 1'b0;
    end else begin
      val_pending           <= next_pending;
      channel_compare_value <= next_ccv;
      rdata                 <= next_rdata;
      chan_pin              <= chan_pin_next;
    end
  end

  // Pin is driven whenever a PWM mode owns it
  assign chan_pin_oe = sc.cpwm | chsc.pwm_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_load_step;
    val_pending && tick && !cnt_wr && dir == tpw_pkg::DIR_UP &&
    cnt == top_less;
  endsequence

  sequence s_loaded;
    ##1 (channel_compare_value == $past(val_buf) && cnt == $past(top));
  endsequence

  load_edge_a: assert property ( // [RULE_01]
    @(posedge ref_clk) disable iff (!reset_n)
    (!sc.cpwm and s_load_step) |-> s_loaded)
    else $error("edge compare not loaded at top step");

  load_center_a: assert property ( // [RULE_02]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm and s_load_step) |-> s_loaded)
    else $error("center compare not loaded at top step");

  load_free_a: assert property ( // [RULE_03]
    @(posedge ref_clk) disable iff (!reset_n)
    (free_run && cnt == (tpw_pkg::COUNT_MAX - tpw_pkg::COUNT_ONE) &&
     val_pending && tick && !cnt_wr && dir == tpw_pkg::DIR_UP)
    |=> (cnt == tpw_pkg::COUNT_MAX &&
         channel_compare_value == $past(val_buf)))
    else $error("free-run compare not loaded at FFFF");

  full_duty_a: assert property ( // [RULE_04]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm && !chsc.low_true && channel_compare_value == top)
    |=> chan_pin)
    else $error("center full duty output dropped");

  near_full_a: assert property ( // [RULE_05]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm && !chsc.low_true && channel_compare_value == top_less &&
     cnt < top_less) |=> chan_pin)
    else $error("near full duty output dropped");

  hold_value_a: assert property ( // [RULE_06]
    @(posedge ref_clk) disable iff (!reset_n)
    (run && !cnt_wr && val_pending && !(tick && cnt == top_less))
    |=> $stable(channel_compare_value))
    else $error("compare changed inside a period");

  old_duty_a: assert property ( // [RULE_07]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm && run && val_pending && val_buf == tpw_pkg::COUNT_ZERO &&
     dir == tpw_pkg::DIR_DOWN) |=> channel_compare_value ==
                                   $past(channel_compare_value))
    else $error("zero duty applied before period end");

  mod_clear_a: assert property ( // [RULE_08]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc_wr && halt_debug_mode) |=> !mod_half)
    else $error("modulo half write survived debug status write");

  cnt_clear_a: assert property ( // [RULE_09]
    @(posedge ref_clk) disable iff (!reset_n)
    cnt_wr |=> (cnt == tpw_pkg::COUNT_ZERO && presc == tpw_pkg::BYTE_ZERO))
    else $error("count write did not clear counter");

  center_turn_a: assert property ( // [RULE_10]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm && tick && !cnt_wr && dir == tpw_pkg::DIR_DOWN &&
     cnt == tpw_pkg::COUNT_ZERO) |=> (dir == tpw_pkg::DIR_UP &&
                                     cnt == tpw_pkg::COUNT_ONE))
    else $error("center counter did not turn at zero");

  center_match_a: assert property ( // [RULE_11]
    @(posedge ref_clk) disable iff (!reset_n)
    (sc.cpwm && !chsc.low_true && channel_compare_value != top &&
     cnt >= channel_compare_value) |=> !chan_pin)
    else $error("center output active beyond match");

  pending_set_a: assert property ( // [RULE_12]
    @(posedge ref_clk) disable iff (!reset_n)
    val_done |=> val_pending)
    else $error("pending flag missed completed pair");

endmodule : tpw_channel

`default_nettype wire

// ===== core/tpw_pkg.sv
package tpw_pkg;

  // ----------------------------------------------------------------
  // Register map (byte registers, 3-bit address)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_SC   = 3'h0;
  localparam logic [2:0] OFS_CNTH = 3'h1;
  localparam logic [2:0] OFS_CNTL = 3'h2;
  localparam logic [2:0] OFS_MODH = 3'h3;
  localparam logic [2:0] OFS_MODL = 3'h4;
  localparam logic [2:0] OFS_CHSC = 3'h5;
  localparam logic [2:0] OFS_CHVH = 3'h6;
  localparam logic [2:0] OFS_CHVL = 3'h7;

  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  PS_ONE     = 8'h01;
  localparam logic [1:0]  CLKS_OFF   = 2'h0;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tpw_bus_t;

  // Timer status and control byte
  typedef struct packed {
    logic [1:0] rsvd;
    logic       cpwm;
    logic [1:0] clock_source_select;
    logic [2:0] ps;
  } tpw_sc_t;

  // Channel control byte; pending is read only
  typedef struct packed {
    logic       pending;
    logic [4:0] rsvd;
    logic       pwm_en;
    logic       low_true;
  } tpw_chsc_t;

  localparam tpw_sc_t   SC_RST   = 8'h00;
  localparam tpw_chsc_t CHSC_RST = 8'h00;

  // Count direction, one-hot
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } tpw_dir_t;

endpackage : tpw_pkg

// ===== core/tpw_pair_buf.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Byte-pair write buffer: completes once both halves are written
// ------------------------------------------------------------------
module tpw_pair_buf (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wdata,
  input  wire logic        clear,
  output logic      [15:0] value,
  output logic             done,
  output logic             half
);

  logic [7:0]  hi_byte;
  logic [7:0]  lo_byte;
  logic        hi_done;
  logic        lo_done;
  logic [7:0]  next_hi_byte;
  logic [7:0]  next_lo_byte;
  logic        next_hi_done;
  logic        next_lo_done;
  logic [15:0] next_value;
  logic        next_done;

  // Either byte order is accepted; the second write completes the pair
  always_comb begin
    next_hi_byte = wr_hi ? wdata : hi_byte;
    next_lo_byte = wr_lo ? wdata : lo_byte;
    next_hi_done = hi_done | wr_hi;
    next_lo_done = lo_done | wr_lo;
    next_value   = value;
    next_done    = 1'b0;
    if (clear) begin
      next_hi_done = 1'b0;
      next_lo_done = 1'b0;
    end else if (next_hi_done && next_lo_done) begin
      next_value   = {next_hi_byte, next_lo_byte};
      next_done    = 1'b1;
      next_hi_done = 1'b0;
      next_lo_done = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_byte <= tpw_pkg::BYTE_ZERO;
      lo_byte <= tpw_pkg::BYTE_ZERO;
      hi_done <= 1'b0;
      lo_done <= 1'b0;
      value   <= tpw_pkg::COUNT_ZERO;
      done    <= 1'b0;
    end else begin
      hi_byte <= next_hi_byte;
      lo_byte <= next_lo_byte;
      hi_done <= next_hi_done;
      lo_done <= next_lo_done;
      value   <= next_value;
      done    <= next_done;
    end
  end

  assign half = hi_done | lo_done;

endmodule : tpw_pair_buf

`default_nettype wire

// ===== dv/tpw_pin_load.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Pin load: integrates the time the channel pin drives high
// ------------------------------------------------------------------
module tpw_pin_load (
  input  wire logic        ref_clk,
  input  wire logic        chan_pin,
  input  wire logic        chan_pin_oe,
  input  wire logic        clr,
  output logic      [15:0] high_count
);
  // Undriven pin is pulled low by the load, so it never counts as high
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      high_count <= 16'h0000;
    end else if (chan_pin_oe && chan_pin) begin
      high_count <= high_count + 16'h0001;
    end
  end
endmodule : tpw_pin_load

`default_nettype wire

// ===== dv/pwm_channel_value_update_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_value_update_bench;
  logic              ref_clk;
  logic              reset_n;
  tpw_pkg::tpw_bus_t bus_req;
  logic              halt_debug_mode;
  logic [7:0]        rdata;
  logic              chan_pin;
  logic              chan_pin_oe;
  logic              clr;
  logic [15:0]       high_count;
  logic [7:0]        exp_q[$];
  logic              rd_last;
  logic [7:0]        rnd;
  int                fail_count;
  int                samples_checked;

  tpw_channel tpw_channel_i (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .bus_req         (bus_req),
    .halt_debug_mode (halt_debug_mode),
    .rdata           (rdata),
    .chan_pin        (chan_pin),
    .chan_pin_oe     (chan_pin_oe)
  );

  tpw_pin_load tpw_pin_load_i (
    .ref_clk     (ref_clk),
    .chan_pin    (chan_pin),
    .chan_pin_oe (chan_pin_oe),
    .clr         (clr),
    .high_count  (high_count)
  );

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Free-running pass needs about 66k cycles; margin on top of that
  initial begin
    #(75000 * 10);
    fail_count++;
    results();
  end

  task automatic results;
    $display("fail_count=%0d samples_checked=%0d", fail_count,
             samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_duty(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_duty

  // Read data stand only in the cycle after the strobe
  always @(negedge ref_clk) begin
    if (rd_last) begin
      chk_byte(rdata, exp_q.pop_front());
    end
    rd_last = bus_req.rd;
  end

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge ref_clk);
    bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : rd

  task automatic halt(input logic v);
    @(posedge ref_clk);
    halt_debug_mode <= v;
  endtask : halt

  task automatic chv(input logic [7:0] hi, input logic [7:0] lo);
    wr(tpw_pkg::OFS_CHVH, hi);
    wr(tpw_pkg::OFS_CHVL, lo);
  endtask : chv

  // Count high cycles over exactly n edges
  task automatic duty(input int n, output logic [15:0] got);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 got = high_count;
  endtask : duty

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] h;
    reset_n         = 1'b0;
    bus_req         = '0;
    halt_debug_mode = 1'b0;
    clr             = 1'b0;
    rd_last         = 1'b0;
    fail_count      = 0;
    samples_checked = 0;
    rnd             = 8'($urandom(32'h5960));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Every register reads zero out of reset
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 8'h00);
    end
    // Edge mode, modulo 8; counting frozen so the load must wait
    halt(1'b1);
    wr(tpw_pkg::OFS_MODH, 8'h00);
    wr(tpw_pkg::OFS_MODL, 8'h08);
    wr(tpw_pkg::OFS_SC, 8'h08);
    wr(tpw_pkg::OFS_CHSC, 8'h02);
    chv(8'h00, 8'h03);
    rd(tpw_pkg::OFS_CHSC, 8'h82);
    rd(tpw_pkg::OFS_CHVL, 8'h00);
    chk_byte({7'h00, chan_pin_oe}, 8'h01);
    halt(1'b0);
    repeat (30) @(posedge ref_clk);
    rd(tpw_pkg::OFS_CHSC, 8'h02);
    rd(tpw_pkg::OFS_CHVL, 8'h03);
    duty(18, h);
    chk_duty(h, 16'h0006);
    // Count write of a random byte clears the frozen counter
    halt(1'b1);
    rnd = 8'($urandom);
    wr(tpw_pkg::OFS_CNTH, rnd);
    rd(tpw_pkg::OFS_CNTH, 8'h00);
    rd(tpw_pkg::OFS_CNTL, 8'h00);
    // Status write while halted drops the half modulo pair
    rnd = 8'($urandom);
    wr(tpw_pkg::OFS_MODH, rnd | 8'h01);
    wr(tpw_pkg::OFS_SC, 8'h08);
    wr(tpw_pkg::OFS_MODL, 8'h20);
    rd(tpw_pkg::OFS_MODH, 8'h00);
    rd(tpw_pkg::OFS_MODL, 8'h08);
    wr(tpw_pkg::OFS_SC, 8'h08);
    // Center mode, compare equal to modulo: always active
    wr(tpw_pkg::OFS_SC, 8'h28);
    chv(8'h00, 8'h08);
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    halt(1'b0);
    repeat (40) @(posedge ref_clk);
    duty(32, h);
    chk_duty(h, 16'h0020);
    // Compare modulo minus one: 13 of 16 counts active
    halt(1'b1);
    chv(8'h00, 8'h07);
    halt(1'b0);
    repeat (40) @(posedge ref_clk);
    duty(32, h);
    chk_duty(h, 16'h001A);
    // Zero then nonzero: old idle output until the new period
    halt(1'b1);
    chv(8'h00, 8'h00);
    halt(1'b0);
    repeat (40) @(posedge ref_clk);
    halt(1'b1);
    chv(8'h00, 8'h04);
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    halt(1'b0);
    duty(6, h);
    chk_duty(h, 16'h0000);
    repeat (10) @(posedge ref_clk);
    duty(16, h);
    chk_duty(h, 16'h0007);
    // Nonzero then zero: counts 1 to 6 still see the old duty of 4
    halt(1'b1);
    chv(8'h00, 8'h00);
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    halt(1'b0);
    duty(6, h);
    chk_duty(h, 16'h0003);
    repeat (20) @(posedge ref_clk);
    duty(16, h);
    chk_duty(h, 16'h0000);
    // Prescaler of two: each count lasts two clocks, 7 counts active
    halt(1'b1);
    wr(tpw_pkg::OFS_SC, 8'h29);
    chv(8'h00, 8'h04);
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    halt(1'b0);
    repeat (40) @(posedge ref_clk);
    duty(32, h);
    chk_duty(h, 16'h000E);
    // Zero written while counting down: rest of period keeps duty 4
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    repeat (20) @(posedge ref_clk);
    chv(8'h00, 8'h00);
    duty(16, h);
    chk_duty(h, 16'h000E);
    repeat (20) @(posedge ref_clk);
    duty(32, h);
    chk_duty(h, 16'h0000);
    // Low-true polarity turns the idle output into a steady high
    wr(tpw_pkg::OFS_CHSC, 8'h03);
    duty(16, h);
    chk_duty(h, 16'h0010);
    wr(tpw_pkg::OFS_CHSC, 8'h02);
    // Clock source off: a completed pair loads two cycles later
    wr(tpw_pkg::OFS_SC, 8'h20);
    chv(8'h00, 8'h06);
    repeat (2) @(posedge ref_clk);
    rd(tpw_pkg::OFS_CHVL, 8'h06);
    rd(tpw_pkg::OFS_CHSC, 8'h02);
    // Free-running counter: load only at the step to the top count
    halt(1'b1);
    wr(tpw_pkg::OFS_MODH, 8'h00);
    wr(tpw_pkg::OFS_MODL, 8'h00);
    wr(tpw_pkg::OFS_SC, 8'h08);
    chv(8'h00, 8'h55);
    wr(tpw_pkg::OFS_CNTL, 8'h00);
    halt(1'b0);
    repeat (65000) @(posedge ref_clk);
    rd(tpw_pkg::OFS_CHSC, 8'h82);
    repeat (700) @(posedge ref_clk);
    rd(tpw_pkg::OFS_CHSC, 8'h02);
    rd(tpw_pkg::OFS_CHVL, 8'h55);
    repeat (4) @(posedge ref_clk);
    results();
  end
endmodule : pwm_channel_value_update_bench

`default_nettype wire
